// *** rtl/bccr_config_regs.sv ***
// Behaviour
// [R01] Layout applies while transparentMode is high; otherwise accesses are not claimed.
// [R02] Write-one-clear bits clear where written 1, unchanged where written 0.
// [R03] Dword 00h bits 15:0 return the fixed maker code, read only.
// [R04] Dword 00h bits 31:16 return the fixed part code, read only.
// [R05] Command bit 0 read/write; gates I/O response on the primary side.
// [R06] Command bit 1 read/write; gates memory read acceptance on the primary side.
// [R07] Command bit 2 gates primary mastering and secondary memory/I/O response.
// [R08] Command bit 3 reads 0; special cycles never claimed.
// [R09] Command bit 4 reads 0; no self-originated write-and-invalidate.
// [R10] Bit 5 writable only in reverse mode; snoops palette writes 3C6h/3C8h/3C9h.
// [R11] Bit 6 set lets parity or poison events set the parity error status.
// [R12] Command bit 7 reads 0, wait cycle control absent.
// [R13] Bit 8 gates upstream error messages forward, system error pin reverse.
// [R14] Command bit 9 reads 0, fast back-to-back absent.
// [R15] In reverse mode bit 10 set blocks the legacy interrupt pin.
// [R16] Status bit 24 sets only with bit 6 set and a primary parity event.
// [R17] Command bits reset to 0; bits 15:11 read 0.
// [R18] Sticky fields survive warm reset; only cold reset clears them. A write-one-clear of bit 24 also clears parityErrSticky.
module bccr_config_regs #(
  parameter logic [15:0] MAKER_CODE = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0c3c // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic coldRstn,
  // Mode straps
  input wire logic transparentMode,
  input wire logic reverseMode,
  // Configuration access
  input wire logic cfgRead,
  input wire logic cfgWrite,
  input wire logic [11:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWdata,
  output logic [31:0] cfgRdata,
  output logic cfgAck,
  // Primary and secondary side requests
  input wire logic primIoReq,
  input wire logic primIoWrite,
  input wire logic [31:0] primIoAddr,
  input wire logic primMemRdReq,
  input wire logic secMemIoReq,
  input wire logic fwdMasterReq,
  input wire logic specialCycleReq,
  // Error and interrupt sources
  input wire logic parityEvent,
  input wire logic errorEvent,
  input wire logic intRequest,
  // Gated results
  output logic primIoClaim,
  output logic primMemRdClaim,
  output logic secMemIoClaim,
  output logic primMasterGo,
  output logic specialClaim,
  output logic paletteClaim,
  output logic errMsgSend,
  output logic system_error_n,
  output logic legacy_interrupt_a_n,
  // Control view
  output logic [15:0] commandView,
  output logic parityErrSticky
);
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic parErr_reg;
  logic parErr_next;
  logic hit;
  logic wrCmd;
  logic [15:0] wmask;
  logic [15:0] wbytes;
  logic paletteHit;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  assign hit = transparentMode; // [R01]
  assign wrCmd = hit && cfgWrite && (cfgAddr == bccr_pkg::OFF_CMD);
  assign wmask = reverseMode ? bccr_pkg::CMD_WMASK_REV : bccr_pkg::CMD_WMASK_FWD; // [R10]
  assign wbytes = {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}} & wmask;

  ////////////////////////////////////////////////////////////////////////////
  // Command register

  always_comb begin
    cmd_next = cmd_reg;
    if (wrCmd) begin
      // Read-only bits 3,4,7,9,15:11 are absent from both masks
      cmd_next = (cmd_reg & ~wbytes) | (cfgWdata[15:0] & wbytes); // [R05] [R06] [R17]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_reg <= bccr_pkg::CMD_RESET; // [R17]
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parity error status, write one to clear

  always_comb begin
    parErr_next = parErr_reg;
    if (wrCmd && cfgByteEn[3] && cfgWdata[bccr_pkg::STAT_PARITY_ERR]) begin
      parErr_next = 1'b0; // [R02]
    end
    // Set beats clear in the same cycle so no event is lost
    if (parityEvent && cmd_reg[bccr_pkg::CMD_PARITY_EN]) begin
      parErr_next = 1'b1; // [R11] [R16]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      parErr_reg <= bccr_pkg::STAT_RESET;
    end else begin
      parErr_reg <= parErr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle answer

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfgRdata <= 32'h00000000;
      cfgAck <= 1'b0;
    end else begin
      cfgAck <= hit && (cfgRead || cfgWrite);
      cfgRdata <= 32'h00000000;
      if (hit && cfgRead) begin
        unique case (cfgAddr)
          bccr_pkg::OFF_IDENT: cfgRdata <= {PART_CODE, MAKER_CODE}; // [R03] [R04]
          bccr_pkg::OFF_CMD: cfgRdata <= {7'h00, parErr_reg, 8'h00, cmd_reg}; // [R08] [R09] [R12] [R14]
          default: cfgRdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Palette snoop decode

  bccr_palette_decode u_palette (
    .core_clk(core_clk),
    .rstn(rstn),
    .snoopEnable(reverseMode && cmd_reg[bccr_pkg::CMD_PALETTE]),
    .ioWriteValid(primIoReq && primIoWrite),
    .ioAddress(primIoAddr),
    .paletteHit(paletteHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transaction gating, registered so outputs leave from flops

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      primIoClaim <= 1'b0;
      primMemRdClaim <= 1'b0;
      secMemIoClaim <= 1'b0;
      primMasterGo <= 1'b0;
      specialClaim <= 1'b0;
      paletteClaim <= 1'b0;
    end else begin
      primIoClaim <= primIoReq && cmd_reg[bccr_pkg::CMD_IO_EN]; // [R05]
      primMemRdClaim <= primMemRdReq && cmd_reg[bccr_pkg::CMD_MEM_EN]; // [R06]
      secMemIoClaim <= secMemIoReq && cmd_reg[bccr_pkg::CMD_MASTER_EN]; // [R07]
      primMasterGo <= fwdMasterReq && cmd_reg[bccr_pkg::CMD_MASTER_EN]; // [R07]
      specialClaim <= 1'b0 && specialCycleReq; // [R08]
      paletteClaim <= paletteHit; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error signalling and interrupt pin

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      errMsgSend <= 1'b0;
      system_error_n <= 1'b1;
      legacy_interrupt_a_n <= 1'b1;
    end else begin
      errMsgSend <= !reverseMode && errorEvent && cmd_reg[bccr_pkg::CMD_SERR_EN]; // [R13]
      system_error_n <= !(reverseMode && errorEvent && cmd_reg[bccr_pkg::CMD_SERR_EN]); // [R13]
      legacy_interrupt_a_n <= !(reverseMode && intRequest &&
        !cmd_reg[bccr_pkg::CMD_INT_DIS]); // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Views

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      commandView <= bccr_pkg::CMD_RESET;
    end else begin
      commandView <= cmd_next;
    end
  end

  // Sticky copy of the parity flag: only cold reset or a write-one-clear of bit 24 clears it
  always_ff @(posedge core_clk) begin
    if (!coldRstn) begin
      parityErrSticky <= 1'b0; // [R18]
    end else if (parityEvent && cmd_reg[bccr_pkg::CMD_PARITY_EN]) begin
      parityErrSticky <= 1'b1; // [R18]
    end else if (wrCmd && cfgByteEn[3] && cfgWdata[bccr_pkg::STAT_PARITY_ERR]) begin
      parityErrSticky <= 1'b0; // [R02]
    end
  end
endmodule

// *** rtl/bccr_pkg.sv ***
package bccr_pkg;
  // Register word offsets (byte addresses of aligned dwords)
  localparam logic [11:0] OFF_IDENT = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  // Command field positions
  localparam int CMD_IO_EN = 0;
  localparam int CMD_MEM_EN = 1;
  localparam int CMD_MASTER_EN = 2;
  localparam int CMD_SPECIAL = 3;
  localparam int CMD_MWI = 4;
  localparam int CMD_PALETTE = 5;
  localparam int CMD_PARITY_EN = 6;
  localparam int CMD_WAIT = 7;
  localparam int CMD_SERR_EN = 8;
  localparam int CMD_FAST_B2B = 9;
  localparam int CMD_INT_DIS = 10;
  // Status field position inside the dword at OFF_CMD
  localparam int STAT_PARITY_ERR = 24;
  // Writable command bits, by bridge direction
  localparam logic [15:0] CMD_WMASK_FWD = 16'h0547;
  localparam logic [15:0] CMD_WMASK_REV = 16'h0567;
  // Values after reset
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic STAT_RESET = 1'b0;
  // Palette snoop addresses, low ten bits
  localparam logic [9:0] PAL_ADDR_A = 10'h3c6;
  localparam logic [9:0] PAL_ADDR_B = 10'h3c8;
  localparam logic [9:0] PAL_ADDR_C = 10'h3c9;
endpackage

// *** rtl/bccr_palette_decode.sv ***
module bccr_palette_decode (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Request
  input wire logic snoopEnable,
  input wire logic ioWriteValid,
  input wire logic [31:0] ioAddress,
  // Result
  output logic paletteHit
);
  function automatic logic isPalette(input logic [9:0] addr);
    isPalette = (addr == bccr_pkg::PAL_ADDR_A) || (addr == bccr_pkg::PAL_ADDR_B) ||
      (addr == bccr_pkg::PAL_ADDR_C);
  endfunction

  // Upper address bits are ignored so ISA aliases also hit
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      paletteHit <= 1'b0;
    end else begin
      paletteHit <= snoopEnable && ioWriteValid && isPalette(ioAddress[9:0]); // [R10]
    end
  end
endmodule

// *** tb/bccr_host_model.sv ***
module bccr_host_model (
  // Clock
  input wire logic core_clk,
  // Configuration access
  output logic cfgRead,
  output logic cfgWrite,
  output logic [11:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWdata,
  input wire logic [31:0] cfgRdata,
  input wire logic cfgAck
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cfgRead, cfgWrite, cfgAddr, cfgByteEn, cfgWdata} = '0;
  // Released lines are inverted so a stale address or data cannot pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] rd, output logic ack);
    @(negedge core_clk);
    {cfgWrite, cfgRead} = {w, !w};
    {cfgAddr, cfgByteEn, cfgWdata} = {a, be, d};
    @(negedge core_clk);
    {ack, rd} = {cfgAck, cfgRdata};
    {cfgRead, cfgWrite} = 2'b00;
    {cfgAddr, cfgWdata} = {~a, ~d};
  endtask
endmodule

// *** tb/bccr_config_regs_sva.sv ***
module bccr_config_regs_chk (
  input wire logic core_clk, rstn, transparentMode, reverseMode, cfgRead, cfgWrite, cfgAck,
  input wire logic primIoReq, primIoClaim, primMemRdReq, primMemRdClaim, specialClaim,
  input wire logic errorEvent, errMsgSend, intRequest, legacy_interrupt_a_n,
  input wire logic [15:0] commandView
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_ack_taken:
    assert property ((cfgRead || cfgWrite) && transparentMode |=> cfgAck) else $error("no ack");
  chk_ack_spurious:
    assert property (!((cfgRead || cfgWrite) && transparentMode) |=> !cfgAck) else $error("ack");
  chk_io_gate:
    assert property (primIoReq |=> primIoClaim == $past(commandView[0])) else $error("io");
  chk_mem_gate:
    assert property (primMemRdReq |=> primMemRdClaim == $past(commandView[1])) else $error("mem");
  chk_special_never:
    assert property (!specialClaim) else $error("special claimed");
  chk_ro_zero:
    assert property ((commandView & 16'hfa98) == 16'h0000) else $error("ro bits set");
  chk_int_block:
    assert property (!(reverseMode && intRequest && !commandView[10]) |=> legacy_interrupt_a_n)
      else $error("int");
  chk_err_send:
    assert property (errorEvent && !reverseMode |=> errMsgSend == $past(commandView[8]))
      else $error("err msg");
endmodule
bind bccr_config_regs bccr_config_regs_chk u_chk (.core_clk, .rstn, .transparentMode,
  .reverseMode, .cfgRead, .cfgWrite, .cfgAck, .primIoReq, .primIoClaim, .primMemRdReq,
  .primMemRdClaim, .specialClaim, .errorEvent, .errMsgSend, .intRequest,
  .legacy_interrupt_a_n, .commandView);

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
  logic core_clk = 0, rstn = 0, coldRstn = 0, transparentMode = 1, reverseMode = 0;
  logic primIoReq = 0, primIoWrite = 0, primMemRdReq = 0, secMemIoReq = 0, fwdMasterReq = 0;
  logic specialCycleReq = 0, parityEvent = 0, errorEvent = 0, intRequest = 0, ack;
  logic [31:0] primIoAddr = '0, cfgWdata, cfgRdata, rd;
  logic [11:0] cfgAddr;
  logic [3:0] cfgByteEn;
  logic [15:0] commandView;
  logic cfgRead, cfgWrite, cfgAck, primIoClaim, primMemRdClaim, secMemIoClaim, primMasterGo;
  logic specialClaim, paletteClaim, errMsgSend, system_error_n, legacy_interrupt_a_n;
  logic parityErrSticky;
  logic [9:0] pal [4] = '{10'h3c6, 10'h3c8, 10'h3c9, 10'h3c7};
  int compares = 0, miscompares = 0, cycles = 0;
  // Identity codes are arbitrary
  bccr_config_regs #(.MAKER_CODE(16'h3a3a), .PART_CODE(16'h5c5c)) uut (.core_clk, .rstn,
    .coldRstn, .transparentMode, .reverseMode, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn,
    .cfgWdata, .cfgRdata, .cfgAck, .primIoReq, .primIoWrite, .primIoAddr, .primMemRdReq,
    .secMemIoReq, .fwdMasterReq, .specialCycleReq, .parityEvent, .errorEvent, .intRequest,
    .primIoClaim, .primMemRdClaim, .secMemIoClaim, .primMasterGo, .specialClaim, .paletteClaim,
    .errMsgSend, .system_error_n, .legacy_interrupt_a_n, .commandView, .parityErrSticky);
  bccr_host_model host (.core_clk, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWdata,
    .cfgRdata, .cfgAck);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    host.xfer(1'b1, a, be, d, rd, ack);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 4'hf, 32'h0, rd, ack);
    `CHK("ack", 1'b1, ack)
    `CHK("rdata", e, rd)
  endtask
  // All requests plus the error and interrupt events for one cycle; registered results land one cycle later
  task automatic gate(input logic [7:0] e);
    @(negedge core_clk);
    {primIoReq, primMemRdReq, secMemIoReq, fwdMasterReq, specialCycleReq, errorEvent} = '1;
    intRequest = 1'b1;
    @(negedge core_clk);
    {primIoReq, primMemRdReq, secMemIoReq, fwdMasterReq, specialCycleReq, errorEvent} = '0;
    intRequest = 1'b0;
    `CHK("gated", e, {primIoClaim, primMemRdClaim, secMemIoClaim, primMasterGo, specialClaim,
      errMsgSend, system_error_n, legacy_interrupt_a_n})
  endtask
  task automatic pulse(ref logic s, input logic v);
    @(negedge core_clk);
    s = v;
    @(negedge core_clk);
    s = !v;
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    {rstn, coldRstn} = 2'b11;
    rdchk(12'h004, 32'h0);
    wr(12'h000, 4'hf, 32'h0);
    rdchk(12'h000, 32'h5c5c3a3a);
    rdchk(12'h008, 32'h0);
    gate(8'h03);
    wr(12'h004, 4'h3, 32'hffff);
    rdchk(12'h004, 32'h0547);
    gate(8'hf7);
    reverseMode = 1'b1;
    wr(12'h004, 4'h3, 32'hffff);
    rdchk(12'h004, 32'h0567);
    gate(8'hf1);
    foreach (pal[i]) begin
      @(negedge core_clk);
      {primIoReq, primIoWrite, primIoAddr} = {2'b11, 22'h3ffff5, pal[i]};
      @(negedge core_clk);
      {primIoReq, primIoWrite} = 2'b00;
      // Claim leaves two edges after the request and stands one cycle
      @(negedge core_clk);
      `CHK("palette", (i < 3) ? 1'b1 : 1'b0, paletteClaim)
    end
    wr(12'h004, 4'h3, 32'h0127);
    gate(8'hf0);
    pulse(parityEvent, 1'b1);
    rdchk(12'h004, 32'h0127);
    wr(12'h004, 4'h3, 32'h0167);
    pulse(parityEvent, 1'b1);
    wr(12'h004, 4'h8, 32'h0);
    rdchk(12'h004, 32'h01000167);
    wr(12'h004, 4'h8, 32'h01000000);
    rdchk(12'h004, 32'h0167);
    pulse(parityEvent, 1'b1);
    pulse(rstn, 1'b0);
    `CHK("sticky", 1'b1, parityErrSticky)
    rdchk(12'h004, 32'h0);
    pulse(coldRstn, 1'b0);
    `CHK("sticky", 1'b0, parityErrSticky)
    transparentMode = 1'b0;
    host.xfer(1'b0, 12'h000, 4'hf, 32'h0, rd, ack);
    `CHK("opaque ack", 1'b0, ack)
    test_done();
  end
endmodule
